// file: inc/mfr_regs.vh
// Functional notes
// [RULE1] Four-bit torque current limit code maps to sixteen ampere steps, 0.125 to 8 A.
// [RULE2] Comparator lock current threshold uses the same sixteen-step ampere table.
// [RULE3] Converter-sampled lock current threshold uses the same ampere table.
// [RULE4] Memory fault latches when its bit is 0, only reports when 1; code ignores MFR_C1_NVM, sticky status and indicator either way.
// [RULE5] Lock current codes 0-2 latch, assert indicator, then tristate, low or high brake.
// [RULE6] Codes 3-5 auto-retry after retry time; past the limit, latch with that action.
// [RULE7] Code 6 only reports with indicator asserted; code 7 disables the detection.
// [RULE8] Motor lock response uses the same eight-code encoding from its own field.
// [RULE9] Comparator lock response uses the same eight-code encoding from its own field.
// [RULE10] Sampled lock detection deglitched by a code: none, or 0.1 to 1000 ms.
// [RULE11] Retry wait chosen by code: 300 ms, 500 ms, then 1 to 14 s.
// [RULE12] Checksum error latches and tristates when bit is 0, only reports when 1.
// [RULE13] Position-detect faults and loop saturation reported only when enabled.
// [RULE14] Retry limit code: 0 unlimited, else 2, 3, 5, 7, 10, 15, 20 attempts.
// [RULE15] Overspeed, bad back-EMF and absent motor checks run only when enabled.
// [RULE16] Overspeed threshold 130 to 200 percent of maximum speed in 10 percent steps.
// [RULE17] Back-EMF threshold 40 to 70 percent with the odd 67.5 step.
// [RULE18] Absent motor current threshold from eight steps, 0.0375 to 1.0 A.
// [RULE19] Bus faults trip at threshold, clear past threshold by 0.5, 1, 2 or 3 V.
// [RULE20] Minimum bus voltage code: 0 no limit, else 6 to 18 V.
// [RULE21] Bus faults latch when recovery bit is 0, self-clear when 1.
// [RULE22] Maximum bus voltage code: 0 no limit, else 18 to 34 V.
// [RULE23] Latched faults hold output state until clear; retry count resets on good clear.
`ifndef MFR_REGS_VH
`define MFR_REGS_VH

// Register offsets
`define MFR_OFS_CFG1 8'h90
`define MFR_OFS_CFG2 8'h92
`define MFR_OFS_STAT 8'h94
`define MFR_RST_CFG 32'h00000000

// First settings word
`define MFR_C1_ILIM 30:27
`define MFR_C1_CMP_THR 26:23
`define MFR_C1_ADC_THR 22:19
`define MFR_C1_NVM 18
`define MFR_C1_ADC_MODE 17:15
`define MFR_C1_DEG 14:11
`define MFR_C1_RETRY 10:7
`define MFR_C1_CRC 6
`define MFR_C1_STALL 5:3
`define MFR_C1_IPD_TO 2
`define MFR_C1_IPD_FQ 1
`define MFR_C1_SAT 0

// Second settings word
`define MFR_C2_OVS_EN 30
`define MFR_C2_BEMF_EN 29
`define MFR_C2_ABS_EN 28
`define MFR_C2_OVS 27:25
`define MFR_C2_BEMF 24:22
`define MFR_C2_ABS 21:19
`define MFR_C2_CMP_MODE 18:16
`define MFR_C2_CMP_DEG 15:13
`define MFR_C2_HYS 12:11
`define MFR_C2_UV 10:8
`define MFR_C2_UV_AUTO 7
`define MFR_C2_OV 6:4
`define MFR_C2_OV_AUTO 3
`define MFR_C2_LIMIT 2:0

// Status word, clear strobe in bit 0 on write
`define MFR_ST_CLR 0

// Timing: base tick for deglitch and retry
`define MFR_CLK_NS 10
`define MFR_TICK_NS 100000
`define MFR_TICK_CYC (`MFR_TICK_NS / `MFR_CLK_NS)

`endif

// file: src/mfr_fault_cfg.v
// Strobed register access was decided locally.
`timescale 1ns/1ns
`include "mfr_regs.vh"

////////////////////////////////////////////////////////////////////////
// One lock-type fault source with latch, retry, report, disable handling
module mfr_resp (
	input wire clk,
	input wire rst_n,
	input wire tick,
	input wire [2:0] mode,
	input wire det,
	input wire [17:0] retry_ticks,
	input wire [4:0] limit,
	input wire clr,
	output reg fault_q,
	output reg [1:0] act_q
);
	localparam S_IDLE = 2'd0;
	localparam S_WAIT = 2'd1;
	localparam S_LATCH = 2'd2;

	reg [1:0] st_q;
	reg [17:0] tmr_q;
	reg [4:0] cnt_q;
	wire [1:0] act_sel;
	wire retry_due;

	// Action code: 1 tristate, 2 low brake, 3 high brake
	assign act_sel = (mode < 3'd3) ? mode[1:0] + 2'd1 : mode[1:0] + 2'd2;
	assign retry_due = ({tmr_q} + 18'd1) >= retry_ticks;

	always @(posedge clk) begin
		if (!rst_n) begin
			st_q <= S_IDLE;
			tmr_q <= 18'd0;
			cnt_q <= 5'd0;
			fault_q <= 1'b0;
			act_q <= 2'd0;
		end else begin
			case (st_q)
			S_IDLE: begin
				// [RULE7] report only or disabled
				if (det && mode == 3'd6) begin
					fault_q <= 1'b1;
				end else if (det && mode < 3'd3) begin
					// [RULE5] latch with chosen action
					st_q <= S_LATCH;
					fault_q <= 1'b1;
					act_q <= act_sel;
				end else if (det && mode != 3'd7) begin
					fault_q <= 1'b1;
					act_q <= act_sel;
					tmr_q <= 18'd0;
					// [RULE6] retry until limit exceeded
					if (limit != 5'd0 && cnt_q >= limit) begin
						st_q <= S_LATCH;
					end else begin
						st_q <= S_WAIT;
					end
				end else begin
					if (clr) begin
						fault_q <= 1'b0;
					end
					// [RULE23] clean run for a retry period resets count
					if (tick && cnt_q != 5'd0) begin
						if (retry_due) begin
							cnt_q <= 5'd0;
							tmr_q <= 18'd0;
						end else begin
							tmr_q <= tmr_q + 18'd1;
						end
					end
				end
			end
			S_WAIT: begin
				// [RULE11] hold action for the retry wait
				if (tick) begin
					if (retry_due) begin
						st_q <= S_IDLE;
						fault_q <= 1'b0;
						act_q <= 2'd0;
						tmr_q <= 18'd0;
						if (cnt_q != 5'd31) begin
							cnt_q <= cnt_q + 5'd1;
						end
					end else begin
						tmr_q <= tmr_q + 18'd1;
					end
				end
			end
			S_LATCH: begin
				// [RULE23] held until clear; a live detection wins
				if (clr && !det) begin
					st_q <= S_IDLE;
					fault_q <= 1'b0;
					act_q <= 2'd0;
					cnt_q <= 5'd0;
					tmr_q <= 18'd0;
				end
			end
			default: begin
				st_q <= S_IDLE;
			end
			endcase
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////
// Fault settings bank and response engine
module mfr_fault_cfg #(
	parameter TICK_CYC = `MFR_TICK_CYC
) (
	input wire clk,
	input wire rst_n,
	input wire [7:0] addr,
	input wire [31:0] wdata,
	input wire wr,
	input wire rd,
	output reg [31:0] rdata,
	input wire [12:0] phase_ma,
	input wire cmp_lock_trip,
	input wire overspeed_det,
	input wire bad_backemf_det,
	input wire absent_motor_det,
	input wire nvm_err,
	input wire crc_err,
	input wire ipd_timeout_det,
	input wire ipd_freq_det,
	input wire loop_sat_det,
	input wire [8:0] bus_dv,
	output reg fault_indicator_pin_n,
	output reg [1:0] drive_state,
	output reg [12:0] torque_ilimit_ma,
	output reg [12:0] comparator_lock_current_thr,
	output reg [7:0] overspeed_threshold,
	output reg [7:0] bad_backemf_threshold,
	output reg [13:0] absent_motor_current_thr
);
	reg [31:0] cfg1_q;
	reg [31:0] cfg2_q;
	reg [13:0] div_q;
	reg tick_q;
	reg [13:0] deg_q;
	reg [9:0] st_q;
	reg uv_q;
	reg ov_q;
	wire clr;
	wire adc_raw;
	wire adc_det;
	wire stall_det;
	wire [13:0] deg_lim;
	wire [17:0] retry_ticks;
	wire [4:0] limit;
	wire [12:0] adc_thr;
	wire [8:0] uv_thr;
	wire [8:0] ov_thr;
	wire [8:0] hys;
	wire adc_f;
	wire cmp_f;
	wire stall_f;
	wire [1:0] adc_a;
	wire [1:0] cmp_a;
	wire [1:0] stall_a;

	// [RULE1] ampere table in milliamps
	function [12:0] amp_ma;
		input [3:0] c;
		begin
			if (c < 4'd3) begin
				amp_ma = 13'd125 << c;
			end else if (c < 4'd14) begin
				amp_ma = 13'd500 * {9'd0, c - 4'd1};
			end else begin
				amp_ma = (c == 4'he) ? 13'd7000 : 13'd8000;
			end
		end
	endfunction

	// Deglitch length in 0.1 ms ticks
	function [13:0] deg_ticks;
		input [3:0] c;
		begin
			case (c)
			4'h0: deg_ticks = 14'd0;
			4'h1: deg_ticks = 14'd1;
			4'h2: deg_ticks = 14'd2;
			4'h3: deg_ticks = 14'd5;
			4'h4: deg_ticks = 14'd10;
			4'h5: deg_ticks = 14'd25;
			4'h6: deg_ticks = 14'd50;
			4'h7: deg_ticks = 14'd75;
			4'h8: deg_ticks = 14'd100;
			4'h9: deg_ticks = 14'd250;
			4'ha: deg_ticks = 14'd500;
			4'hb: deg_ticks = 14'd750;
			4'hc: deg_ticks = 14'd1000;
			4'hd: deg_ticks = 14'd2000;
			4'he: deg_ticks = 14'd5000;
			default: deg_ticks = 14'd10000;
			endcase
		end
	endfunction

	// Retry wait in 0.1 ms ticks
	function [17:0] rty_ticks;
		input [3:0] c;
		begin
			if (c == 4'h0) begin
				rty_ticks = 18'd3000;
			end else if (c == 4'h1) begin
				rty_ticks = 18'd5000;
			end else begin
				rty_ticks = 18'd10000 * {14'd0, c - 4'd1};
			end
		end
	endfunction

	function [4:0] tries;
		input [2:0] c;
		begin
			case (c)
			3'd0: tries = 5'd0;
			3'd1: tries = 5'd2;
			3'd2: tries = 5'd3;
			3'd3: tries = 5'd5;
			3'd4: tries = 5'd7;
			3'd5: tries = 5'd10;
			3'd6: tries = 5'd15;
			default: tries = 5'd20;
			endcase
		end
	endfunction

	// Bus limits in 0.1 V; zero means no limit
	function [8:0] uv_dv;
		input [2:0] c;
		begin
			case (c)
			3'd0: uv_dv = 9'd0;
			3'd1: uv_dv = 9'd60;
			3'd2: uv_dv = 9'd70;
			3'd3: uv_dv = 9'd80;
			3'd4: uv_dv = 9'd100;
			3'd5: uv_dv = 9'd140;
			3'd6: uv_dv = 9'd160;
			default: uv_dv = 9'd180;
			endcase
		end
	endfunction

	function [8:0] ov_dv;
		input [2:0] c;
		begin
			case (c)
			3'd0: ov_dv = 9'd0;
			3'd1: ov_dv = 9'd180;
			3'd2: ov_dv = 9'd200;
			3'd3: ov_dv = 9'd220;
			3'd4: ov_dv = 9'd280;
			3'd5: ov_dv = 9'd300;
			3'd6: ov_dv = 9'd320;
			default: ov_dv = 9'd340;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// Register port
	assign clr = wr && addr == `MFR_OFS_STAT && wdata[`MFR_ST_CLR];

	always @(posedge clk) begin
		if (!rst_n) begin
			cfg1_q <= `MFR_RST_CFG;
			cfg2_q <= `MFR_RST_CFG;
			rdata <= 32'h00000000;
		end else begin
			// Top bit is a read-only parity slot, kept zero
			if (wr && addr == `MFR_OFS_CFG1) begin
				cfg1_q <= {1'b0, wdata[30:0]};
			end
			if (wr && addr == `MFR_OFS_CFG2) begin
				cfg2_q <= {1'b0, wdata[30:0]};
			end
			case (addr)
			`MFR_OFS_CFG1: rdata <= rd ? cfg1_q : 32'h00000000;
			`MFR_OFS_CFG2: rdata <= rd ? cfg2_q : 32'h00000000;
			`MFR_OFS_STAT: rdata <= rd ? {20'h00000, drive_state, st_q} : 32'h00000000;
			default: rdata <= 32'h00000000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// 0.1 ms tick for all slow timing
	always @(posedge clk) begin
		if (!rst_n) begin
			div_q <= 14'd0;
			tick_q <= 1'b0;
		end else if (div_q >= TICK_CYC[13:0] - 14'd1) begin
			div_q <= 14'd0;
			tick_q <= 1'b1;
		end else begin
			div_q <= div_q + 14'd1;
			tick_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Thresholds handed to the detectors
	// [RULE3] sampled lock threshold
	assign adc_thr = amp_ma(cfg1_q[`MFR_C1_ADC_THR]);
	assign adc_raw = phase_ma >= adc_thr;
	assign deg_lim = deg_ticks(cfg1_q[`MFR_C1_DEG]);

	always @(posedge clk) begin
		if (!rst_n) begin
			torque_ilimit_ma <= 13'd0;
			comparator_lock_current_thr <= 13'd0;
			overspeed_threshold <= 8'd0;
			bad_backemf_threshold <= 8'd0;
			absent_motor_current_thr <= 14'd0;
		end else begin
			// [RULE1] torque limit
			torque_ilimit_ma <= amp_ma(cfg1_q[`MFR_C1_ILIM]);
			// [RULE2] comparator threshold
			comparator_lock_current_thr <= amp_ma(cfg1_q[`MFR_C1_CMP_THR]);
			// [RULE16] percent of maximum speed
			overspeed_threshold <= 8'd130 + 8'd10 * {5'd0, cfg2_q[`MFR_C2_OVS]};
			// [RULE17] half-percent units; 67.5 is the odd step
			case (cfg2_q[`MFR_C2_BEMF])
			3'd6: bad_backemf_threshold <= 8'd135;
			3'd7: bad_backemf_threshold <= 8'd140;
			default: bad_backemf_threshold <= 8'd80 + 8'd10 * {5'd0, cfg2_q[`MFR_C2_BEMF]};
			endcase
			// [RULE18] units of 0.1 mA
			case (cfg2_q[`MFR_C2_ABS])
			3'd0: absent_motor_current_thr <= 14'd375;
			3'd1: absent_motor_current_thr <= 14'd750;
			3'd2: absent_motor_current_thr <= 14'd1000;
			3'd3: absent_motor_current_thr <= 14'd1250;
			3'd4: absent_motor_current_thr <= 14'd2500;
			3'd5: absent_motor_current_thr <= 14'd5000;
			3'd6: absent_motor_current_thr <= 14'd7500;
			default: absent_motor_current_thr <= 14'd10000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// [RULE10] deglitch the sampled lock, counts in ticks
	always @(posedge clk) begin
		if (!rst_n || !adc_raw) begin
			deg_q <= 14'd0;
		end else if (tick_q && deg_q < deg_lim) begin
			deg_q <= deg_q + 14'd1;
		end
	end
	assign adc_det = adc_raw && deg_q >= deg_lim;

	// [RULE15] lock checks gated by their enables
	assign stall_det = (overspeed_det && cfg2_q[`MFR_C2_OVS_EN])
		|| (bad_backemf_det && cfg2_q[`MFR_C2_BEMF_EN])
		|| (absent_motor_det && cfg2_q[`MFR_C2_ABS_EN]);

	// [RULE11] retry wait
	assign retry_ticks = rty_ticks(cfg1_q[`MFR_C1_RETRY]);
	// [RULE14] retry limit
	assign limit = tries(cfg2_q[`MFR_C2_LIMIT]);

	mfr_resp u_adc (
		.clk(clk),
		.rst_n(rst_n),
		.tick(tick_q),
		.mode(cfg1_q[`MFR_C1_ADC_MODE]),
		.det(adc_det),
		.retry_ticks(retry_ticks),
		.limit(limit),
		.clr(clr),
		.fault_q(adc_f),
		.act_q(adc_a)
	);

	// [RULE9] comparator lock response; no deglitch applied here
	mfr_resp u_cmp (
		.clk(clk),
		.rst_n(rst_n),
		.tick(tick_q),
		.mode(cfg2_q[`MFR_C2_CMP_MODE]),
		.det(cmp_lock_trip),
		.retry_ticks(retry_ticks),
		.limit(limit),
		.clr(clr),
		.fault_q(cmp_f),
		.act_q(cmp_a)
	);

	// [RULE8] motor lock response
	mfr_resp u_stall (
		.clk(clk),
		.rst_n(rst_n),
		.tick(tick_q),
		.mode(cfg1_q[`MFR_C1_STALL]),
		.det(stall_det),
		.retry_ticks(retry_ticks),
		.limit(limit),
		.clr(clr),
		.fault_q(stall_f),
		.act_q(stall_a)
	);

	////////////////////////////////////////////////////////////////////
	// Bus voltage window
	assign uv_thr = uv_dv(cfg2_q[`MFR_C2_UV]);
	assign ov_thr = ov_dv(cfg2_q[`MFR_C2_OV]);
	// [RULE19] hysteresis in 0.1 V
	assign hys = (cfg2_q[`MFR_C2_HYS] == 2'd0) ? 9'd5 : 9'd10 * {7'd0, cfg2_q[`MFR_C2_HYS]}
		+ ((cfg2_q[`MFR_C2_HYS] == 2'd3) ? 9'd0 : 9'd0);

	always @(posedge clk) begin
		if (!rst_n) begin
			uv_q <= 1'b0;
			ov_q <= 1'b0;
		end else begin
			// [RULE20] trip below minimum
			if (uv_thr != 9'd0 && bus_dv < uv_thr) begin
				uv_q <= 1'b1;
			// [RULE21] self-clear or wait for software
			end else if ((cfg2_q[`MFR_C2_UV_AUTO] || clr)
				&& ({1'b0, bus_dv} >= {1'b0, uv_thr} + {1'b0, hys} || uv_thr == 9'd0)) begin
				uv_q <= 1'b0;
			end
			// [RULE22] trip above maximum
			if (ov_thr != 9'd0 && bus_dv > ov_thr) begin
				ov_q <= 1'b1;
			end else if ((cfg2_q[`MFR_C2_OV_AUTO] || clr)
				&& ({1'b0, bus_dv} + {1'b0, hys} <= {1'b0, ov_thr} || ov_thr == 9'd0)) begin
				ov_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Sticky status; an event in the clear cycle wins
	always @(posedge clk) begin
		if (!rst_n) begin
			st_q <= 10'd0;
		end else begin
			st_q[2:0] <= {stall_f, cmp_f, adc_f};
			// [RULE4] latched or report only, both sticky
			st_q[3] <= nvm_err || (st_q[3] && !clr);
			// [RULE12] checksum error
			st_q[4] <= crc_err || (st_q[4] && !clr);
			// [RULE13] gated diagnostics
			st_q[5] <= (ipd_timeout_det && cfg1_q[`MFR_C1_IPD_TO]) || (st_q[5] && !clr);
			st_q[6] <= (ipd_freq_det && cfg1_q[`MFR_C1_IPD_FQ]) || (st_q[6] && !clr);
			st_q[7] <= (loop_sat_det && cfg1_q[`MFR_C1_SAT]) || (st_q[7] && !clr);
			st_q[9:8] <= {ov_q, uv_q};
		end
	end

	////////////////////////////////////////////////////////////////////
	// Output state and indicator; tristate is the safest and wins
	always @(posedge clk) begin
		if (!rst_n) begin
			drive_state <= 2'd0;
			fault_indicator_pin_n <= 1'b1;
		end else begin
			// [RULE12] latched checksum fault tristates
			if (adc_a == 2'd1 || cmp_a == 2'd1 || stall_a == 2'd1
				|| (st_q[4] && !cfg1_q[`MFR_C1_CRC])) begin
				drive_state <= 2'd1;
			end else if (adc_a == 2'd2 || cmp_a == 2'd2 || stall_a == 2'd2) begin
				drive_state <= 2'd2;
			end else if (adc_a == 2'd3 || cmp_a == 2'd3 || stall_a == 2'd3) begin
				drive_state <= 2'd3;
			end else begin
				drive_state <= 2'd0;
			end
			// [RULE5] indicator on any active fault except saturation
			fault_indicator_pin_n <= !(|st_q[6:0] || |st_q[9:8]);
		end
	end
endmodule

// file: tb/mfr_fault_cfg_assertions.sv
`timescale 1ns/1ns
module mfr_fault_cfg_chk (
	input wire clk,
	input wire rst_n,
	input wire [7:0] addr,
	input wire [31:0] wdata,
	input wire wr,
	input wire rd,
	input wire [31:0] rdata,
	input wire fault_indicator_pin_n,
	input wire [1:0] drive_state,
	input wire [12:0] torque_ilimit_ma,
	input wire [12:0] comparator_lock_current_thr,
	input wire [7:0] overspeed_threshold,
	input wire [7:0] bad_backemf_threshold,
	input wire [13:0] absent_motor_current_thr
);
	logic [31:0] c1_q;
	logic [31:0] c2_q;
	function automatic logic [12:0] amp(input logic [3:0] c);
		if (c < 4'h3) amp = 13'd125 << c;
		else if (c > 4'hd) amp = 13'd7000 + 13'd1000 * (c - 4'he);
		else amp = 13'd1000 + 13'd500 * (c - 4'h3);
	endfunction
	function automatic logic [13:0] absent(input logic [2:0] c);
		case (c)
			3'h0: absent = 14'd375;
			3'h1: absent = 14'd750;
			3'h2: absent = 14'd1000;
			3'h3: absent = 14'd1250;
			3'h4: absent = 14'd2500;
			3'h5: absent = 14'd5000;
			3'h6: absent = 14'd7500;
			default: absent = 14'd10000;
		endcase
	endfunction
	// Shadow of the two settings words, top bit never stored
	always @(posedge clk) begin
		if (!rst_n) begin
			c1_q <= 32'h0;
			c2_q <= 32'h0;
		end else if (wr && addr == 8'h90) begin
			c1_q <= {1'b0, wdata[30:0]};
		end else if (wr && addr == 8'h92) begin
			c2_q <= {1'b0, wdata[30:0]};
		end
	end
	////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_read_cfg1: assert property (
		rd && addr == 8'h90 |=> rdata == c1_q) else $error("settings one readback wrong");
	a_read_cfg2: assert property (
		rd && addr == 8'h92 |=> rdata == c2_q) else $error("settings two readback wrong");
	a_ilimit_map: assert property (
		$past(rst_n) && $past(rst_n, 2) |-> torque_ilimit_ma == amp($past(c1_q[30:27])))
		else $error("torque limit decode wrong");
	a_cmp_thr_map: assert property (
		$past(rst_n) && $past(rst_n, 2)
		|-> comparator_lock_current_thr == amp($past(c1_q[26:23])))
		else $error("comparator threshold decode wrong");
	a_overspeed_map: assert property (
		$past(rst_n) && $past(rst_n, 2)
		|-> overspeed_threshold == 8'd130 + 8'd10 * $past(c2_q[27:25]))
		else $error("overspeed decode wrong");
	a_bemf_map: assert property (
		$past(rst_n) && $past(rst_n, 2) |-> bad_backemf_threshold ==
		($past(c2_q[24:22]) == 3'h6 ? 8'd135 : $past(c2_q[24:22]) == 3'h7 ? 8'd140 :
		8'd80 + 8'd10 * $past(c2_q[24:22]))) else $error("back-emf decode wrong");
	a_absent_map: assert property (
		$past(rst_n) && $past(rst_n, 2)
		|-> absent_motor_current_thr == absent($past(c2_q[21:19])))
		else $error("absent motor decode wrong");
	a_action_ind: assert property (
		$rose(drive_state != 2'h0) |-> ##[0:3] !fault_indicator_pin_n)
		else $error("drive action without indicator");
endmodule
bind mfr_fault_cfg mfr_fault_cfg_chk u_chk (.clk(clk), .rst_n(rst_n), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.fault_indicator_pin_n(fault_indicator_pin_n), .drive_state(drive_state),
	.torque_ilimit_ma(torque_ilimit_ma),
	.comparator_lock_current_thr(comparator_lock_current_thr),
	.overspeed_threshold(overspeed_threshold), .bad_backemf_threshold(bad_backemf_threshold),
	.absent_motor_current_thr(absent_motor_current_thr));

// file: tb/mfr_fault_cfg_tb.sv
`timescale 1ns/1ns
module mfr_fault_cfg_tb;
	logic clk;
	logic rst_n;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	logic [9:0] ev;
	logic [8:0] bus_dv;
	wire [31:0] rdata;
	wire [12:0] phase_ma;
	wire ind_n;
	wire [1:0] drive;
	wire [12:0] ilim;
	wire [12:0] cthr;
	wire [7:0] ovs;
	wire [7:0] bemf;
	wire [13:0] absn;
	integer seed;
	integer failures;
	integer comparisons;
	integer i;
	logic [31:0] got;
	logic [31:0] r;
	logic [31:0] c1;
	logic [31:0] c2;
	// Over every threshold code so the sampled check trips
	assign phase_ma = ev[9] ? 13'd8100 : 13'd0;
	mfr_fault_cfg #(.TICK_CYC(1)) uut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .phase_ma(phase_ma), .cmp_lock_trip(ev[3]),
		.overspeed_det(ev[0]), .bad_backemf_det(ev[1]), .absent_motor_det(ev[2]),
		.nvm_err(ev[4]), .crc_err(ev[5]), .ipd_timeout_det(ev[6]), .ipd_freq_det(ev[7]),
		.loop_sat_det(ev[8]), .bus_dv(bus_dv), .fault_indicator_pin_n(ind_n),
		.drive_state(drive), .torque_ilimit_ma(ilim), .comparator_lock_current_thr(cthr),
		.overspeed_threshold(ovs), .bad_backemf_threshold(bemf),
		.absent_motor_current_thr(absn));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////
	function automatic logic [31:0] amp(input logic [3:0] c);
		if (c < 4'h3) amp = 32'd125 << c;
		else if (c > 4'hd) amp = 32'd7000 + 32'd1000 * (c - 4'he);
		else amp = 32'd1000 + 32'd500 * (c - 4'h3);
	endfunction
	function automatic logic [31:0] bemf_exp(input logic [2:0] c);
		bemf_exp = c == 3'h7 ? 32'd140 : c == 3'h6 ? 32'd135 : 32'd80 + 32'd10 * c;
	endfunction
	function automatic logic [31:0] absn_exp(input logic [2:0] c);
		logic [31:0] t [8];
		t = '{375, 750, 1000, 1250, 2500, 5000, 7500, 10000};
		absn_exp = t[c];
	endfunction
	task automatic final_report;
		$display("failures=%0d comparisons=%0d", failures, comparisons);
		if (failures == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] e, input logic [31:0] a);
		comparisons = comparisons + 1;
		if (a !== e) begin
			failures = failures + 1;
			$display("mismatch t=%0t exp=%h got=%h", $time, e, a);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		got = rdata;
	endtask
	// Bounded wait; running out ends the run
	task automatic wait_ind(input logic e, input integer n);
		integer k;
		for (k = 0; k < n && ind_n !== e; k++) begin
			@(posedge clk);
			#1;
		end
		check({31'h0, e}, {31'h0, ind_n});
		if (ind_n !== e) final_report;
	endtask
	task automatic bus_step(input logic [8:0] v, input logic e);
		@(posedge clk);
		bus_dv <= v;
		repeat (10) @(posedge clk);
		#1;
		check({31'h0, e}, {31'h0, ind_n});
	endtask
	// Detection held as a level, then dropped well before the clear
	task automatic fcase(input logic [31:0] s1, input logic [31:0] s2, input integer b,
		input logic [1:0] d, input logic e, input logic [31:0] st);
		wr_reg(8'h90, s1);
		wr_reg(8'h92, s2);
		@(posedge clk);
		ev[b] <= 1'b1;
		repeat (20) @(posedge clk);
		#1;
		check({30'h0, d}, {30'h0, drive});
		check({31'h0, e}, {31'h0, ind_n});
		rd_reg(8'h94);
		check(st, got & 32'h3f8);
		@(posedge clk);
		ev <= 10'h0;
		repeat (4) @(posedge clk);
		wr_reg(8'h94, 32'h1);
		wait_ind(1'b1, 20);
		check(32'h0, {30'h0, drive});
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		seed = 75;
		failures = 0;
		comparisons = 0;
		rst_n = 1'b0;
		addr = 8'h0;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
		ev = 10'h0;
		bus_dv = 9'd180;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		check(32'h1, {31'h0, ind_n});
		check(32'd375, absn);
		rd_reg(8'h92);
		check(32'h0, got);
		for (i = 0; i < 16; i++) begin
			r = $random(seed);
			c1 = {r[31], i[3:0], ~i[3:0], r[22:0]};
			c2 = {r[31:28], i[2:0], i[2:0], i[2:0], r[18:0]};
			wr_reg(8'h90, c1);
			wr_reg(8'h92, c2);
			rd_reg(8'h90);
			check({1'b0, c1[30:0]}, got);
			rd_reg(8'h92);
			check({1'b0, c2[30:0]}, got);
			check(amp(i[3:0]), ilim);
			check(amp(~i[3:0]), cthr);
			check(32'd130 + 32'd10 * i[2:0], ovs);
			check(bemf_exp(i[2:0]), bemf);
			check(absn_exp(i[2:0]), absn);
		end
		wr_reg(8'h96, 32'hffffffff);
		rd_reg(8'h96);
		check(32'h0, got);
		rd_reg(8'h92);
		check({1'b0, c2[30:0]}, got);
		bus_dv <= 9'd180;
		for (i = 0; i < 3; i++) begin
			fcase(i << 3, 32'h40000000, 0, 2'(i + 1), 1'b0, 32'h0);
		end
		fcase(32'h30, 32'h40000000, 0, 2'h0, 1'b0, 32'h0);
		fcase(32'h38, 32'h40000000, 0, 2'h0, 1'b1, 32'h0);
		fcase(32'h0, 32'h0, 0, 2'h0, 1'b1, 32'h0);
		fcase(32'h0, 32'h20000000, 1, 2'h1, 1'b0, 32'h0);
		fcase(32'h0, 32'h10000000, 2, 2'h1, 1'b0, 32'h0);
		fcase(32'h0, 32'h00010000, 3, 2'h2, 1'b0, 32'h0);
		fcase(32'h0, 32'h00070000, 3, 2'h0, 1'b1, 32'h0);
		fcase(32'h10000, 32'h0, 9, 2'h3, 1'b0, 32'h0);
		fcase(32'h0, 32'h0, 4, 2'h0, 1'b0, 32'h8);
		fcase(32'h40000, 32'h0, 4, 2'h0, 1'b0, 32'h8);
		fcase(32'h0, 32'h0, 5, 2'h1, 1'b0, 32'h10);
		fcase(32'h40, 32'h0, 5, 2'h0, 1'b0, 32'h10);
		fcase(32'h4, 32'h0, 6, 2'h0, 1'b0, 32'h20);
		fcase(32'h0, 32'h0, 6, 2'h0, 1'b1, 32'h0);
		fcase(32'h2, 32'h0, 7, 2'h0, 1'b0, 32'h40);
		fcase(32'h1, 32'h0, 8, 2'h0, 1'b1, 32'h80);
		fcase(32'h0, 32'h0, 8, 2'h0, 1'b1, 32'h0);
		// Auto retry: 300 ms code is 3000 ticks of one cycle here
		wr_reg(8'h90, 32'h18);
		wr_reg(8'h92, 32'h40000000);
		@(posedge clk);
		ev[0] <= 1'b1;
		@(posedge clk);
		ev <= 10'h0;
		repeat (2900) @(posedge clk);
		#1;
		check(32'h1, {30'h0, drive});
		wait_ind(1'b1, 300);
		check(32'h0, {30'h0, drive});
		wr_reg(8'h92, 32'h180);
		bus_step(9'd59, 1'b0);
		bus_step(9'd64, 1'b0);
		bus_step(9'd65, 1'b1);
		wr_reg(8'h92, 32'h100);
		bus_step(9'd59, 1'b0);
		bus_step(9'd180, 1'b0);
		wr_reg(8'h94, 32'h1);
		wait_ind(1'b1, 20);
		wr_reg(8'h92, 32'h1818);
		bus_step(9'd181, 1'b0);
		bus_step(9'd151, 1'b0);
		bus_step(9'd150, 1'b1);
		final_report;
	end
endmodule
